// File: cpu_state_regfile.sv
// Architectural state: flags, working registers, pointer pairs, stack pointer
//
// Summary of operation
// - Arithmetic on two registers or register and immediate finishes in one cycle.
// - Status flags are updated after every ALU operation except SWAP and MOV.
// - Flags are never saved or restored automatically around interrupts.
// - Flag bit 7 is global interrupt enable; zero blocks every interrupt.
// - Interrupt entry clears enable; interrupt return and enable instruction set it.
// - Bit 6 is a copy bit, stored from and loaded to a register bit.
// - Bit 5 records carry out of the low nibble.
// - Bit 4 equals negative XOR overflow unless the flags are loaded by an I/O write.
// - Bit 3 records two's complement overflow.
// - Bit 2 records a set most significant result bit.
// - Bit 1 is set for an all-zero result, cleared otherwise.
// - Bit 0 captures the carry.
// - File offers 8-bit and 16-bit read and write port schemes.
// - Working registers appear at the first 32 data addresses.
// - Six top registers form three 16-bit pointer pairs.
// - Pointers support displacement, post-increment and pre-decrement.
// - Push lowers stack pointer by one; call or interrupt by two.
// - Pop raises stack pointer by one; returns by two.
// - Stack pointer is two 8-bit I/O registers, zero at reset.
`timescale 1ns/1ps
`include "cpu_state_defines.svh"
module cpu_state_regfile (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // Arithmetic request from the decoder
  input  wire logic                      alu_en,
  input  wire cpu_state_pkg::alu_op_t    alu_op,
  input  wire logic                      alu_use_imm,
  input  wire logic [7:0]                alu_imm,
  // Register file read ports
  input  wire logic [4:0]                rd_addr_a,
  input  wire logic [4:0]                rd_addr_b,
  output logic [7:0]                     rd_data_a,
  output logic [7:0]                     rd_data_b,
  output logic [15:0]                    rd_data_wide,
  // Register file write port
  input  wire logic                      wr_en,
  input  wire logic                      wr_wide,
  input  wire logic [4:0]                wr_addr,
  input  wire logic [15:0]               wr_data,
  // Bit copy instructions
  input  wire logic                      bit_store_instr,
  input  wire logic                      bit_load_instr,
  input  wire logic [2:0]                bit_sel,
  // Interrupt enable control
  input  wire logic                      irq_taken,
  input  wire logic                      interrupt_return_instr,
  input  wire logic                      gie_set_instr,
  input  wire logic                      gie_clear_instr,
  input  wire logic                      irq_request,
  output logic                           irq_accept_ok,
  // Pointer pair addressing
  input  wire logic                      ptr_en,
  input  wire logic [1:0]                ptr_sel,
  input  wire cpu_state_pkg::ptr_mode_t  ptr_mode,
  input  wire logic [5:0]                ptr_disp,
  output logic [15:0]                    ptr_addr,
  // Stack pointer adjust
  input  wire cpu_state_pkg::sp_op_t     sp_op,
  output logic [15:0]                    stack_addr,
  // Data space access to working registers
  input  wire logic [15:0]               ds_addr,
  input  wire logic                      ds_wr,
  input  wire logic [7:0]                ds_wdata,
  output logic                           ds_hit,
  output logic [7:0]                     ds_rdata,
  // I/O space access
  input  wire logic [5:0]                io_addr,
  input  wire logic                      io_wr,
  input  wire logic [7:0]                io_wdata,
  output logic [7:0]                     io_rdata,
  // State view
  output logic [7:0]                     status_flags_register,
  output logic [15:0]                    stack_ptr
);
  typedef struct packed {
    logic [`NUM_WORK_REGS-1:0][7:0] regs;
    logic [7:0]                     flags;
    logic [15:0]                    sp;
    logic [7:0]                     rd_a;
    logic [7:0]                     rd_b;
    logic [15:0]                    rd_w;
    logic [7:0]                     ds_rd;
    logic [7:0]                     io_rd;
    logic [15:0]                    p_addr;
    logic [15:0]                    s_addr;
  } state_t;

  state_t state_reg;
  state_t state_next;
  cpu_state_pkg::alu_out_t alu_res;
  logic [7:0] alu_b;
  logic [4:0] ptr_low;
  logic [15:0] ptr_val;
  logic [15:0] ptr_new;
  logic [4:0] ptr_lo_q;

  // Low register index of a pointer pair; 3 falls back to the last pair
  function automatic logic [4:0] pair_low(input logic [1:0] sel);
    case (sel)
      2'h0:    pair_low = `PTR_X_LOW;
      2'h1:    pair_low = `PTR_Y_LOW;
      default: pair_low = `PTR_Z_LOW;
    endcase
  endfunction

  // Register file occupies data addresses 0..31
  function automatic logic in_reg_space(input logic [15:0] a);
    in_reg_space = (a[15:5] == 11'h000);
  endfunction

  assign alu_b = alu_use_imm ? alu_imm : state_reg.regs[rd_addr_a ^ 5'h00 ^ rd_addr_b ^ rd_addr_a];

  cpu_alu u_alu (
    .op       (alu_op),
    .opa      (state_reg.regs[rd_addr_a]),
    .opb      (alu_b),
    .flags_in (state_reg.flags),
    .res      (alu_res)
  );

  assign ptr_low = pair_low(ptr_sel);
  assign ptr_lo_q = ptr_low + 5'h01;
  assign ptr_val = {state_reg.regs[ptr_lo_q], state_reg.regs[ptr_low]};

  always_comb begin
    state_next = state_reg;
    ptr_new = ptr_val;
    // Read ports are registered; data appears one edge after the address
    state_next.rd_a = state_reg.regs[rd_addr_a];
    state_next.rd_b = state_reg.regs[rd_addr_b];
    state_next.rd_w = {state_reg.regs[{rd_addr_a[4:1], 1'b1}],
                       state_reg.regs[{rd_addr_a[4:1], 1'b0}]};
    state_next.ds_rd = state_reg.regs[ds_addr[4:0]];
    // Plain write port; the arithmetic result to rd_addr_a takes precedence over it
    if (wr_en) begin
      if (wr_wide) begin
        state_next.regs[{wr_addr[4:1], 1'b0}] = wr_data[7:0];
        state_next.regs[{wr_addr[4:1], 1'b1}] = wr_data[15:8];
      end else begin
        state_next.regs[wr_addr] = wr_data[7:0];
      end
    end
    if (alu_en) begin
      state_next.regs[rd_addr_a] = alu_res.result;
      state_next.flags = alu_res.flags;
    end
    if (ds_wr && in_reg_space(ds_addr)) begin
      state_next.regs[ds_addr[4:0]] = ds_wdata;
    end
    // Bit copy
    if (bit_store_instr) begin
      state_next.flags[`FLAG_COPY] = state_reg.regs[rd_addr_a][bit_sel];
    end
    if (bit_load_instr) begin
      state_next.regs[rd_addr_a][bit_sel] = state_reg.flags[`FLAG_COPY];
    end
    // Pointer addressing; the updated pointer wins over other writes
    if (ptr_en) begin
      case (ptr_mode)
        cpu_state_pkg::PTR_POSTINC: begin
          state_next.p_addr = ptr_val;
          ptr_new = ptr_val + 16'h0001;
        end
        cpu_state_pkg::PTR_PREDEC: begin
          ptr_new = ptr_val - 16'h0001;
          state_next.p_addr = ptr_new;
        end
        default: state_next.p_addr = ptr_val + {10'h000, ptr_disp};
      endcase
      state_next.regs[ptr_low] = ptr_new[7:0];
      state_next.regs[ptr_lo_q] = ptr_new[15:8];
    end
    // I/O space: stack pointer halves and flags
    case (io_addr)
      `IO_ADDR_STACK_PTR_LOW:  state_next.io_rd = state_reg.sp[7:0];
      `IO_ADDR_STACK_PTR_HIGH: state_next.io_rd = state_reg.sp[15:8];
      `IO_ADDR_STATUS_FLAGS:   state_next.io_rd = state_reg.flags;
      default:                 state_next.io_rd = 8'h00;
    endcase
    if (io_wr) begin
      case (io_addr)
        `IO_ADDR_STACK_PTR_LOW:  state_next.sp[7:0] = io_wdata;
        `IO_ADDR_STACK_PTR_HIGH: state_next.sp[15:8] = io_wdata;
        `IO_ADDR_STATUS_FLAGS:   state_next.flags = io_wdata;
        default: ;
      endcase
    end
    // Stack grows down; push stores at sp then decrements, pop increments first
    case (sp_op)
      cpu_state_pkg::SP_PUSH: begin
        state_next.s_addr = state_reg.sp;
        state_next.sp = state_reg.sp - 16'h0001;
      end
      cpu_state_pkg::SP_CALL: begin
        state_next.s_addr = state_reg.sp;
        state_next.sp = state_reg.sp - 16'h0002;
      end
      cpu_state_pkg::SP_POP: begin
        state_next.s_addr = state_reg.sp + 16'h0001;
        state_next.sp = state_reg.sp + 16'h0001;
      end
      cpu_state_pkg::SP_RET: begin
        state_next.s_addr = state_reg.sp + 16'h0001;
        state_next.sp = state_reg.sp + 16'h0002;
      end
      default: ;
    endcase
    // Interrupt enable: entry and disable beat return and enable
    // Flags are left alone on entry and return; handlers save them
    if (interrupt_return_instr || gie_set_instr) begin
      state_next.flags[`FLAG_GIE] = 1'b1;
    end
    if (irq_taken || gie_clear_instr) begin
      state_next.flags[`FLAG_GIE] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.flags <= `RST_STATUS_FLAGS;
      state_reg.sp <= `RST_STACK_PTR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Disable takes effect in its own cycle
  assign irq_accept_ok = irq_request & state_reg.flags[`FLAG_GIE] & ~gie_clear_instr;
  assign rd_data_a = state_reg.rd_a;
  assign rd_data_b = state_reg.rd_b;
  assign rd_data_wide = state_reg.rd_w;
  assign ds_hit = in_reg_space(ds_addr);
  assign ds_rdata = state_reg.ds_rd;
  assign io_rdata = state_reg.io_rd;
  assign ptr_addr = state_reg.p_addr;
  assign stack_addr = state_reg.s_addr;
  assign status_flags_register = state_reg.flags;
  assign stack_ptr = state_reg.sp;
endmodule // cpu_state_regfile

// File: cpu_state_defines.svh
// Offsets, field positions, reset values and counts of the CPU state block
`ifndef CPU_STATE_DEFINES_SVH
`define CPU_STATE_DEFINES_SVH
`define IO_ADDR_STACK_PTR_LOW   6'h3d
`define IO_ADDR_STACK_PTR_HIGH  6'h3e
`define IO_ADDR_STATUS_FLAGS    6'h3f
`define RST_STACK_PTR           16'h0000
`define RST_STATUS_FLAGS        8'h00
`define FLAG_GIE                7
`define FLAG_COPY               6
`define FLAG_HALF               5
`define FLAG_SIGN               4
`define FLAG_OVF                3
`define FLAG_NEG                2
`define FLAG_ZERO               1
`define FLAG_CARRY              0
`define NUM_WORK_REGS           32
`define PTR_X_LOW               5'h1a
`define PTR_Y_LOW               5'h1c
`define PTR_Z_LOW               5'h1e
`endif

// File: cpu_state_pkg.sv
// Types shared by the CPU state block
package cpu_state_pkg;
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
    ALU_AND = 4'h4, ALU_OR  = 4'h5, ALU_XOR = 4'h6, ALU_MOV = 4'h7,
    ALU_INC = 4'h8, ALU_DEC = 4'h9, ALU_COM = 4'ha, ALU_NEG = 4'hb,
    ALU_LSR = 4'hc, ALU_ROR = 4'hd, ALU_ASR = 4'he, ALU_SWAP = 4'hf
  } alu_op_t;
  typedef enum logic [2:0] {
    SP_NONE = 3'h0, SP_PUSH = 3'h1, SP_POP = 3'h2, SP_CALL = 3'h3, SP_RET = 3'h4
  } sp_op_t;
  typedef enum logic [1:0] {
    PTR_DISP = 2'h0, PTR_POSTINC = 2'h1, PTR_PREDEC = 2'h2
  } ptr_mode_t;
  typedef struct packed {
    logic [7:0] result;
    logic [7:0] flags;
  } alu_out_t;
endpackage

// File: cpu_alu.sv
// Single-cycle arithmetic unit with flag generation
`timescale 1ns/1ps
`include "cpu_state_defines.svh"
module cpu_alu (
  // Operation
  input  wire cpu_state_pkg::alu_op_t op,
  input  wire logic [7:0]             opa,
  input  wire logic [7:0]             opb,
  input  wire logic [7:0]             flags_in,
  // Result
  output cpu_state_pkg::alu_out_t     res
);
  logic [8:0] sum;
  logic [7:0] r;
  logic       h;
  logic       v;
  logic       c;
  logic [7:0] f;

  always_comb begin
    sum = 9'h0_00;
    r = opa;
    h = flags_in[`FLAG_HALF];
    v = 1'b0;
    c = flags_in[`FLAG_CARRY];
    case (op)
      cpu_state_pkg::ALU_ADD, cpu_state_pkg::ALU_ADC: begin
        sum = {1'b0, opa} + {1'b0, opb}
            + {8'h00, (op == cpu_state_pkg::ALU_ADC) & flags_in[`FLAG_CARRY]};
        r = sum[7:0];
        c = sum[8];
        h = (opa[3] & opb[3]) | (opb[3] & ~r[3]) | (~r[3] & opa[3]);
        v = (opa[7] & opb[7] & ~r[7]) | (~opa[7] & ~opb[7] & r[7]);
      end
      cpu_state_pkg::ALU_SUB, cpu_state_pkg::ALU_SBC: begin
        sum = {1'b0, opa} - {1'b0, opb}
            - {8'h00, (op == cpu_state_pkg::ALU_SBC) & flags_in[`FLAG_CARRY]};
        r = sum[7:0];
        c = sum[8];
        h = (~opa[3] & opb[3]) | (opb[3] & r[3]) | (r[3] & ~opa[3]);
        v = (opa[7] & ~opb[7] & ~r[7]) | (~opa[7] & opb[7] & r[7]);
      end
      cpu_state_pkg::ALU_AND: r = opa & opb;
      cpu_state_pkg::ALU_OR:  r = opa | opb;
      cpu_state_pkg::ALU_XOR: r = opa ^ opb;
      cpu_state_pkg::ALU_MOV: r = opb;
      cpu_state_pkg::ALU_INC: begin
        r = opa + 8'h01;
        v = (opa == 8'h7f);
      end
      cpu_state_pkg::ALU_DEC: begin
        r = opa - 8'h01;
        v = (opa == 8'h80);
      end
      cpu_state_pkg::ALU_COM: begin
        r = ~opa;
        c = 1'b1;
      end
      cpu_state_pkg::ALU_NEG: begin
        r = 8'h00 - opa;
        c = (r != 8'h00);
        v = (r == 8'h80);
        h = r[3] | opa[3];
      end
      cpu_state_pkg::ALU_LSR: begin
        r = {1'b0, opa[7:1]};
        c = opa[0];
        v = opa[0];
      end
      cpu_state_pkg::ALU_ROR: begin
        r = {flags_in[`FLAG_CARRY], opa[7:1]};
        c = opa[0];
        v = flags_in[`FLAG_CARRY] ^ opa[0];
      end
      cpu_state_pkg::ALU_ASR: begin
        r = {opa[7], opa[7:1]};
        c = opa[0];
        v = opa[7] ^ opa[0];
      end
      cpu_state_pkg::ALU_SWAP: r = {opa[3:0], opa[7:4]};
      default: r = opa;
    endcase
    f = flags_in;
    if (op != cpu_state_pkg::ALU_SWAP && op != cpu_state_pkg::ALU_MOV) begin
      f[`FLAG_CARRY] = c;
      f[`FLAG_ZERO]  = (r == 8'h00);
      f[`FLAG_NEG]   = r[7];
      f[`FLAG_OVF]   = v;
      f[`FLAG_SIGN]  = r[7] ^ v;
      f[`FLAG_HALF]  = h;
    end
    res.result = r;
    res.flags  = f;
  end
endmodule // cpu_alu

// File: cpu_state_sva.sv
// Port assertions for the CPU state block
`timescale 1ns/1ps
module cpu_state_sva (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  // Observed ports
  input wire cpu_state_pkg::sp_op_t sp_op,
  input wire logic                  io_wr,
  input wire logic                  alu_en,
  input wire logic                  bit_store_instr,
  input wire logic                  irq_taken,
  input wire logic                  interrupt_return_instr,
  input wire logic                  gie_set_instr,
  input wire logic                  gie_clear_instr,
  input wire logic                  irq_request,
  input wire logic                  irq_accept_ok,
  input wire logic [15:0]           ds_addr,
  input wire logic                  ds_hit,
  input wire logic [15:0]           stack_ptr,
  input wire logic [15:0]           stack_addr,
  input wire logic [7:0]            status_flags_register
);
  logic [7:0] f;
  assign f = status_flags_register;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // I/O writes are excluded, though a same-cycle stack operation overrides an I/O load of the pointer
  property p_sp(cpu_state_pkg::sp_op_t op, logic [15:0] d);
    !io_wr && sp_op == op |=> stack_ptr == $past(stack_ptr) + d;
  endproperty
  a_sp_push: assert property (p_sp(cpu_state_pkg::SP_PUSH, 16'hffff)) else $error("bad push");
  a_sp_call: assert property (p_sp(cpu_state_pkg::SP_CALL, 16'hfffe)) else $error("bad call");
  a_sp_pop: assert property (p_sp(cpu_state_pkg::SP_POP, 16'h0001)) else $error("bad pop");
  a_sp_ret: assert property (p_sp(cpu_state_pkg::SP_RET, 16'h0002)) else $error("bad ret");
  a_pop_addr: assert property ((sp_op == cpu_state_pkg::SP_POP ||
    sp_op == cpu_state_pkg::SP_RET) && !io_wr |=> stack_addr == $past(stack_ptr) + 16'h0001)
    else $error("bad pop address");
  a_sign_xor: assert property (alu_en && !io_wr |=> f[4] == (f[2] ^ f[3]))
    else $error("sign flag wrong");
  a_gie_clear: assert property (gie_clear_instr || irq_taken |=> !f[7])
    else $error("enable not cleared");
  a_gie_set: assert property ((gie_set_instr || interrupt_return_instr) &&
    !gie_clear_instr && !irq_taken |=> f[7]) else $error("enable not set");
  a_irq_gate: assert property (irq_accept_ok == (irq_request && f[7] && !gie_clear_instr))
    else $error("interrupt gate wrong");
  a_no_save: assert property (irq_taken && !alu_en && !bit_store_instr && !io_wr
    |=> f[6:0] == $past(f[6:0])) else $error("flags touched on entry");
  a_ds_map: assert property (ds_hit == (ds_addr < 16'h0020)) else $error("bad map");
  c_call: cover property (sp_op == cpu_state_pkg::SP_CALL);
  c_accept: cover property (irq_accept_ok);
  c_entry: cover property (irq_taken ##1 interrupt_return_instr);
endmodule // cpu_state_sva

bind cpu_state_regfile cpu_state_sva sva_u (.*);

// File: sp_boot_model.sv
// Decoder start-up sequence that places the stack pointer
`timescale 1ns/1ps
module sp_boot_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Control
  input  wire logic       start,
  output logic            busy,
  // I/O writes toward the block
  output logic            io_wr,
  output logic [5:0]      io_addr,
  output logic [7:0]      io_wdata
);
  logic [1:0] step_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_reg <= 2'h0;
    end else if (start || step_reg != 2'h0) begin
      step_reg <= step_reg + 2'h1;
    end
  end
  // Stack set to 0x01ff, above the reserved low area, before any call
  assign busy = step_reg != 2'h0;
  assign io_wr = step_reg == 2'h1 || step_reg == 2'h2;
  assign io_addr = (step_reg == 2'h2) ? 6'h3e : 6'h3d;
  assign io_wdata = (step_reg == 2'h2) ? 8'h01 : 8'hff;
endmodule // sp_boot_model

// File: cpu_state_regfile_tb.sv
// Self-checking bench for the CPU state block
`timescale 1ns/1ps
module cpu_state_regfile_tb;
  typedef struct packed {
    logic alu_en, use_imm, wr_en, wr_wide, bit_st, bit_ld, irq_tk, iret, gie_set, gie_clr;
    logic irq_req, ptr_en, ds_wr, io_wr, start;
    cpu_state_pkg::alu_op_t alu_op;
    cpu_state_pkg::ptr_mode_t pmode;
    cpu_state_pkg::sp_op_t sp_op;
    logic [4:0] ra, rb, wa;
    logic [7:0] imm, dsw, iow;
    logic [15:0] wd, dsa;
    logic [5:0] disp, ioa;
    logic [2:0] bsel;
    logic [1:0] psel;
  } req_t;
  typedef struct packed {int due; logic [3:0] sel; logic [15:0] val;} note_t;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  req_t        req, drv;
  note_t       q[$];
  int          cyc = 0, bad_count = 0, samples_checked = 0;
  logic [31:0] seed = 32'hceef_4261, r;
  logic [15:0] sp, ad;
  logic [15:0] dl [5] = '{16'h0000, 16'hffff, 16'h0001, 16'hfffe, 16'h0002};
  logic [7:0]  av [4] = '{8'h0f, 8'h7f, 8'hff, 8'h00};
  logic [7:0]  rv [4] = '{8'h10, 8'h80, 8'h00, 8'hff};
  logic [7:0]  fv [4] = '{8'h20, 8'h2c, 8'h23, 8'h35};
  logic [15:0] pv [3] = '{16'h1239, 16'h1234, 16'h1234};
  cpu_state_pkg::sp_op_t op;
  logic [7:0]  rd_a, rd_b, ds_rdata, io_rdata, flags, b_data;
  logic [15:0] rd_w, ptr_addr, stack_addr, stack_ptr;
  logic        irq_ok, ds_hit, b_busy, b_wr;
  logic [5:0]  b_addr;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  sp_boot_model boot_u (.clk_sys(clk_sys), .rst_n(rst_n), .start(drv.start), .busy(b_busy),
    .io_wr(b_wr), .io_addr(b_addr), .io_wdata(b_data));
  cpu_state_regfile dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .alu_en(drv.alu_en),
    .alu_op(drv.alu_op), .alu_use_imm(drv.use_imm), .alu_imm(drv.imm), .rd_addr_a(drv.ra),
    .rd_addr_b(drv.rb), .rd_data_a(rd_a), .rd_data_b(rd_b), .rd_data_wide(rd_w),
    .wr_en(drv.wr_en), .wr_wide(drv.wr_wide), .wr_addr(drv.wa), .wr_data(drv.wd),
    .bit_store_instr(drv.bit_st), .bit_load_instr(drv.bit_ld), .bit_sel(drv.bsel),
    .irq_taken(drv.irq_tk), .interrupt_return_instr(drv.iret), .gie_set_instr(drv.gie_set),
    .gie_clear_instr(drv.gie_clr), .irq_request(drv.irq_req), .irq_accept_ok(irq_ok),
    .ptr_en(drv.ptr_en), .ptr_sel(drv.psel), .ptr_mode(drv.pmode), .ptr_disp(drv.disp),
    .ptr_addr(ptr_addr), .sp_op(drv.sp_op), .stack_addr(stack_addr), .ds_addr(drv.dsa),
    .ds_wr(drv.ds_wr), .ds_wdata(drv.dsw), .ds_hit(ds_hit), .ds_rdata(ds_rdata),
    .io_addr(b_busy ? b_addr : drv.ioa), .io_wr(b_busy ? b_wr : drv.io_wr),
    .io_wdata(b_busy ? b_data : drv.iow), .io_rdata(io_rdata),
    .status_flags_register(flags), .stack_ptr(stack_ptr));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] got(input logic [3:0] s);
    case (s)
      4'h0: return stack_ptr;
      4'h1: return stack_addr;
      4'h2: return {8'h00, io_rdata};
      4'h3: return {8'h00, flags};
      4'h4: return {8'h00, rd_a};
      4'h5: return {8'h00, rd_b};
      4'h6: return rd_w;
      4'h7: return ptr_addr;
      4'h9: return {15'h0000, irq_ok};
      default: return {8'h00, ds_rdata};
    endcase
  endfunction
  // Pulses last one cycle because the request image is cleared after each launch
  task automatic issue();
    @(posedge clk_sys);
    drv <= req;
    req = req_t'(0);
  endtask
  task automatic note(input logic [3:0] s, input logic [15:0] v);
    q.push_back('{cyc + 2, s, v});
  endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d, input logic w);
    req.wr_en = 1'b1;
    req.wa = a;
    req.wd = d;
    req.wr_wide = w;
    issue();
  endtask
  task automatic compare_val(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    #1;
    while (q.size() > 0 && q[0].due == cyc) begin
      compare_val(q[0].val, got(q[0].sel));
      void'(q.pop_front());
    end
    if (cyc > 400) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    req = req_t'(0);
    drv = req_t'(0);
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      req.ioa = 6'h3d + 6'(i);
      issue();
      note(4'h2, 16'h0000);
    end
    req.start = 1'b1;
    repeat (4) issue();
    note(4'h0, 16'h01ff);
    sp = 16'h01ff;
    for (int i = 0; i < 24; i++) begin
      r = xs();
      op = cpu_state_pkg::sp_op_t'(3'(r % 32'd5));
      ad = (op == cpu_state_pkg::SP_POP || op == cpu_state_pkg::SP_RET) ? sp + 16'h0001 : sp;
      sp = sp + dl[op];
      req.sp_op = op;
      req.irq_req = r[8];
      issue();
      note(4'h0, sp);
      if (op != cpu_state_pkg::SP_NONE)
        note(4'h1, ad);
    end
    r = xs();
    req.io_wr = 1'b1;
    req.ioa = 6'h3d;
    req.iow = r[7:0];
    issue();
    req.io_wr = 1'b1;
    req.ioa = 6'h3e;
    req.iow = r[15:8];
    issue();
    note(4'h0, r[15:0]);
    req.ioa = 6'h3e;
    issue();
    note(4'h2, {8'h00, r[15:8]});
    wreg(5'h0c, 16'h0001, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wreg(5'(i + 8), {8'h00, av[i]}, 1'b0);
      req.alu_en = 1'b1;
      req.alu_op = (i == 3) ? cpu_state_pkg::ALU_SUB : cpu_state_pkg::ALU_ADD;
      req.ra = 5'(i + 8);
      req.rb = 5'h0c;
      req.use_imm = (i != 0);
      req.imm = 8'h01;
      issue();
      note(4'h3, {8'h00, fv[i]});
      req.ra = 5'(i + 8);
      issue();
      note(4'h4, {8'h00, rv[i]});
    end
    wreg(5'h1a, 16'h1234, 1'b1);
    req.ra = 5'h1a;
    req.rb = 5'h08;
    issue();
    note(4'h6, 16'h1234);
    note(4'h5, 16'h0010);
    for (int i = 0; i < 3; i++) begin
      req.ptr_en = 1'b1;
      req.pmode = cpu_state_pkg::ptr_mode_t'(2'(i));
      req.disp = 6'h05;
      issue();
      note(4'h7, pv[i]);
    end
    req.ra = 5'h1a;
    issue();
    note(4'h6, 16'h1234);
    req.ds_wr = 1'b1;
    req.dsa = 16'h0005;
    req.dsw = 8'ha5;
    issue();
    req.ds_wr = 1'b1;
    req.dsa = 16'h0025;
    req.dsw = 8'h5a;
    issue();
    req.dsa = 16'h0005;
    issue();
    note(4'h8, 16'h00a5);
    req.bit_st = 1'b1;
    req.ra = 5'h05;
    issue();
    note(4'h3, 16'h0075);
    req.bit_ld = 1'b1;
    req.ra = 5'h08;
    req.bsel = 3'h3;
    issue();
    req.ra = 5'h08;
    issue();
    note(4'h4, 16'h0018);
    for (int i = 0; i < 4; i++) begin
      req.gie_set = (i == 0);
      req.irq_tk = (i == 1);
      req.iret = (i == 2);
      req.gie_clr = (i == 3);
      req.irq_req = 1'b1;
      issue();
      note(4'h3, (i % 2 == 0) ? 16'h00f5 : 16'h0075);
      // Gate is seen against the next request; only the first one finds enable set, no clear
      note(4'h9, (i == 0) ? 16'h0001 : 16'h0000);
    end
    repeat (3) issue();
    conclude();
  end
endmodule // cpu_state_regfile_tb
